// File: rtl/ebwc_ctrl.sv
// External bus controller for areas 3 to 0: program waits, idle insertion and area 0 burst ROM
//
// Function
// - Two-bit area wait field gives zero, one, two or three program wait states.
// - Wait field applies only to that area's external accesses with three-state bit set.
// - Wait fields: area3 bits 7:6, area2 5:4, area1 3:2, area0 1:0.
// - Wait control register resets to all ones, three waits per area.
// - Idle-insert bit 7 adds one idle state between reads of different areas.
// - Idle-insert bit 6 adds one idle state between a read and following write.
// - Burst-enable bit 5 selects burst ROM interface for area 0.
// - Burst-length bit 4 makes each burst cycle one state or two states.
// - Burst-count bit 3 limits a burst to four or eight words.
// - On-chip memory and internal register accesses never get program waits.
// - Three-state bit set enables wait insertion for that area; clear disables it.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps

module ebwc_ctrl (
   input  wire logic                       aclk,       // System clock, 200 MHz
   input  wire logic                       aresetn,    // Synchronous reset, active low
   input  wire ebwc_pkg::ebwc_axi_req_type axi_req,    // Register bus requests
   output      ebwc_pkg::ebwc_axi_rsp_type axi_rsp,    // Register bus answers
   input  wire ebwc_pkg::ebwc_acc_req_type acc_req,    // CPU access request
   output      logic                       acc_ready,  // Request taken this cycle
   output      ebwc_pkg::ebwc_acc_rsp_type acc_rsp,    // Word completion pulse and data
   output      ebwc_pkg::ebwc_ext_type     ext_bus,    // External address, strobes, data out
   input  wire logic [15:0]                ext_data_i  // External data in
);
   import ebwc_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      ebwc_state_type state;
      logic [1:0]     area;
      logic           write;
      logic           ast;
      logic [1:0]     nwait;
      logic [1:0]     wcnt;
      logic           burst_on;
      logic           blen2;
      logic           bphase;
      logic [3:0]     words_left;
      logic           last_valid;
      logic           last_read;
      logic [1:0]     last_area;
      logic [23:0]    addr;
      logic [15:0]    wdata;
      logic           rsp_valid;
      logic [15:0]    rdata;
      ebwc_ext_type   pins;
   } ebwc_ctrl_st_type;

   ebwc_ctrl_st_type s_ff;
   ebwc_ctrl_st_type nxt_s;
   ebwc_cfg_type     cfg;
   logic [7:0]       status;
   logic             acc_fire;
   logic             need_idle;
   logic             go_t1;
   logic             beat_done;
   logic [3:0]       words_req;
   logic [3:0]       words_max;

   // Select an area's two-bit program wait count
   function automatic logic [1:0] wait_field(input logic [7:0] ctl, input logic [1:0] area);
      unique case (area)
         2'h3:    wait_field = ctl[7:6];
         2'h2:    wait_field = ctl[5:4];
         2'h1:    wait_field = ctl[3:2];
         default: wait_field = ctl[1:0];
      endcase
   endfunction : wait_field

   // ----------------------------------------------------------------
   // Register slave
   // ----------------------------------------------------------------
   ebwc_regs u_regs (
      .aclk    (aclk),
      .aresetn (aresetn),
      .axi_req (axi_req),
      .axi_rsp (axi_rsp),
      .status  (status),
      .cfg     (cfg)
   );

   assign status = {s_ff.last_valid, s_ff.last_read, s_ff.last_area,
                    (s_ff.state != ST_IDLE), s_ff.state};

   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   // One access at a time; a new one is taken only with the bus idle
   assign acc_ready = (s_ff.state == ST_IDLE);
   assign acc_fire  = acc_ready && acc_req.valid;

   // Idle state only between back-to-back external cycles
   assign need_idle = s_ff.last_valid && s_ff.last_read && acc_req.external &&
                      ((!acc_req.write && (acc_req.area != s_ff.last_area) &&
                        cfg.idle_burst[IB_CROSS_READ]) ||
                       (acc_req.write && cfg.idle_burst[IB_READ_WRITE]));

   // Requested words clamped to the burst limit
   assign words_max = cfg.idle_burst[IB_BURST_CNT] ? BURST_WORDS_LONG : BURST_WORDS_SHORT;
   always_comb begin
      words_req = (acc_req.words == 4'h0) ? 4'h1 : acc_req.words;
      if (words_req > words_max) begin
         words_req = words_max;
      end
   end

   // ----------------------------------------------------------------
   // Bus cycle sequencer
   // ----------------------------------------------------------------
   always_comb begin
      nxt_s           = s_ff;
      nxt_s.rsp_valid = 1'b0;
      go_t1           = 1'b0;
      beat_done       = 1'b0;
      unique case (s_ff.state)
         ST_IDLE: begin
            if (acc_fire && !acc_req.external) begin
               // Internal targets complete at once and break the external sequence
               nxt_s.rsp_valid  = 1'b1;
               nxt_s.rdata      = 16'h0000;
               nxt_s.last_valid = 1'b0;
            end else if (acc_fire) begin
               nxt_s.area     = acc_req.area;
               nxt_s.write    = acc_req.write;
               nxt_s.addr     = acc_req.addr;
               nxt_s.wdata    = acc_req.wdata;
               nxt_s.ast      = cfg.tristate[acc_req.area];
               nxt_s.nwait    = cfg.tristate[acc_req.area] ?
                                wait_field(cfg.wait_ctl, acc_req.area) : 2'h0;
               nxt_s.wcnt     = 2'h0;
               nxt_s.burst_on = (acc_req.area == 2'h0) && !acc_req.write &&
                                cfg.idle_burst[IB_BURST_EN];
               nxt_s.blen2    = cfg.idle_burst[IB_BURST_LEN];
               nxt_s.bphase   = 1'b0;
               nxt_s.words_left = (acc_req.area == 2'h0) && !acc_req.write &&
                                  cfg.idle_burst[IB_BURST_EN] ? words_req - 4'h1 : 4'h0;
               if (need_idle) begin
                  nxt_s.state = ST_IDLEINS;
               end else begin
                  go_t1 = 1'b1;
               end
            end
         end
         ST_IDLEINS: begin
            go_t1 = 1'b1;
         end
         ST_T1: begin
            nxt_s.state = ST_T2;
         end
         ST_T2: begin
            // Two-state access unless three-state access is selected
            if (!s_ff.ast) begin
               beat_done = 1'b1;
            end else if (s_ff.nwait == 2'h0) begin
               nxt_s.state = ST_T3;
            end else begin
               nxt_s.state = ST_WAIT;
               nxt_s.wcnt  = 2'h1;
            end
         end
         ST_WAIT: begin
            // Pins are not touched here so address and strobes stay put
            if (s_ff.wcnt == s_ff.nwait) begin
               nxt_s.state = ST_T3;
            end else begin
               nxt_s.wcnt = s_ff.wcnt + 2'h1;
            end
         end
         ST_T3: begin
            beat_done = 1'b1;
         end
         ST_BURST: begin
            if (s_ff.blen2 && !s_ff.bphase) begin
               nxt_s.bphase = 1'b1;
            end else begin
               beat_done = 1'b1;
            end
         end
         default: begin
            nxt_s.state = ST_IDLE;
         end
      endcase

      // Start of an external cycle: drive address, area select and strobe
      if (go_t1) begin
         nxt_s.state           = ST_T1;
         nxt_s.pins.addr       = nxt_s.addr;
         nxt_s.pins.area_sel_n = ~(4'h1 << nxt_s.area);
         nxt_s.pins.rd_n       = nxt_s.write;
         nxt_s.pins.wr_n       = !nxt_s.write;
         nxt_s.pins.dout       = nxt_s.wdata;
         nxt_s.pins.doe        = nxt_s.write;
      end

      // Word completes: capture data, then either burst on or release the bus
      if (beat_done) begin
         nxt_s.rsp_valid = 1'b1;
         nxt_s.rdata     = s_ff.write ? 16'h0000 : ext_data_i;
         if (s_ff.burst_on && (s_ff.words_left != 4'h0)) begin
            nxt_s.state      = ST_BURST;
            nxt_s.bphase     = 1'b0;
            nxt_s.words_left = s_ff.words_left - 4'h1;
            nxt_s.pins.addr  = s_ff.pins.addr + EXT_WORD_STEP;
         end else begin
            nxt_s.state           = ST_IDLE;
            nxt_s.pins.area_sel_n = 4'hf;
            nxt_s.pins.rd_n       = 1'b1;
            nxt_s.pins.wr_n       = 1'b1;
            nxt_s.pins.doe        = 1'b0;
            nxt_s.last_valid      = 1'b1;
            nxt_s.last_read       = !s_ff.write;
            nxt_s.last_area       = s_ff.area;
         end
      end
   end

   // Registered state; pins come straight from flip-flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff                 <= '0;
         s_ff.state           <= ST_IDLE;
         s_ff.pins.area_sel_n <= 4'hf;
         s_ff.pins.rd_n       <= 1'b1;
         s_ff.pins.wr_n       <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign ext_bus       = s_ff.pins;
   assign acc_rsp.valid = s_ff.rsp_valid;
   assign acc_rsp.rdata = s_ff.rdata;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_wait_count: assert property (
      (s_ff.state == ST_T3) |-> (s_ff.wcnt == s_ff.nwait))
      else $error("wait states differ from the area wait field");

   chk_wait_gate: assert property (
      (s_ff.state == ST_T2 && !s_ff.ast) |=> (s_ff.state != ST_WAIT && s_ff.state != ST_T3))
      else $error("wait inserted with three-state access off");

   chk_field_map: assert property (
      (acc_fire && acc_req.external && acc_req.area == 2'h3 && cfg.tristate[3])
      |=> (s_ff.nwait == $past(cfg.wait_ctl[7:6])))
      else $error("area 3 wait field taken from wrong bits");

   chk_wait_reset: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> (cfg.wait_ctl == 8'hff))
      else $error("wait control not all ones after reset");

   chk_idle_cross: assert property (
      (acc_fire && acc_req.external && !acc_req.write && s_ff.last_valid && s_ff.last_read &&
       acc_req.area != s_ff.last_area && cfg.idle_burst[7]) |=> (s_ff.state == ST_IDLEINS) ##1
      (s_ff.state == ST_T1))
      else $error("no single idle state between reads of different areas");

   chk_idle_rw: assert property (
      (acc_fire && acc_req.external && acc_req.write && s_ff.last_valid && s_ff.last_read)
      |=> (s_ff.state == (cfg.idle_burst[6] ? ST_IDLEINS : ST_T1)))
      else $error("read to write idle state wrong");

   chk_burst_area: assert property (
      (s_ff.state == ST_BURST) |-> (s_ff.area == 2'h0 && s_ff.burst_on && !s_ff.write))
      else $error("burst outside area 0 burst ROM mode");

   chk_burst_len: assert property (
      (s_ff.state == ST_BURST && s_ff.blen2 && !s_ff.bphase)
      |=> (s_ff.state == ST_BURST && s_ff.bphase && !acc_rsp.valid))
      else $error("two-state burst cycle ended early");

   chk_burst_max: assert property (
      (s_ff.state == ST_T1) |-> (s_ff.words_left <= (cfg.idle_burst[3] ? 4'h7 : 4'h3)))
      else $error("burst longer than the word limit");

   chk_internal_fast: assert property (
      (acc_fire && !acc_req.external) |=> (acc_rsp.valid && s_ff.state == ST_IDLE))
      else $error("internal access delayed");

   chk_wait_enable: assert property (
      (s_ff.state == ST_T1 && s_ff.ast && s_ff.nwait != 2'h0) |-> ##1 (s_ff.state == ST_T2) ##1
      (s_ff.state == ST_WAIT))
      else $error("enabled waits not inserted");

   chk_pins_stable: assert property (
      (s_ff.state == ST_WAIT) |-> ($stable(ext_bus) && (!ext_bus.rd_n || !ext_bus.wr_n)))
      else $error("pins moved during a wait state");

endmodule : ebwc_ctrl

// File: rtl/ebwc_pkg.sv
// Constants, types and register map of the external bus wait, idle and burst controller
package ebwc_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the AXI4-Lite slave)
   // ----------------------------------------------------------------
   localparam int unsigned     AXI_AW           = 5;
   localparam logic [4:0]      OFS_WAIT_CTL     = 5'h00;
   localparam logic [4:0]      OFS_IDLE_BURST   = 5'h04;
   localparam logic [4:0]      OFS_TRISTATE     = 5'h08;
   localparam logic [4:0]      OFS_STATUS       = 5'h0c;

   // Values after reset
   localparam logic [7:0]      WAIT_CTL_RST     = 8'hff;
   localparam logic [7:0]      IDLE_BURST_RST   = 8'hd0;
   localparam logic [7:0]      TRISTATE_RST     = 8'hff;

   // Field positions in idle_burst_bus_control
   localparam int unsigned     IB_CROSS_READ    = 7;
   localparam int unsigned     IB_READ_WRITE    = 6;
   localparam int unsigned     IB_BURST_EN      = 5;
   localparam int unsigned     IB_BURST_LEN     = 4;
   localparam int unsigned     IB_BURST_CNT     = 3;

   // Burst word limits and external word step in bytes
   localparam logic [3:0]      BURST_WORDS_SHORT = 4'h4;
   localparam logic [3:0]      BURST_WORDS_LONG  = 4'h8;
   localparam logic [23:0]     EXT_WORD_STEP     = 24'h000002;

   // AXI responses
   localparam logic [1:0]      RESP_OKAY        = 2'h0;
   localparam logic [1:0]      RESP_SLVERR      = 2'h2;

   // Bus cycle states
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_IDLEINS = 3'b001,
      ST_T1      = 3'b010,
      ST_T2      = 3'b011,
      ST_WAIT    = 3'b100,
      ST_T3      = 3'b101,
      ST_BURST   = 3'b110
   } ebwc_state_type;

   typedef struct packed {
      logic [7:0] wait_ctl;    // low_area_wait_control
      logic [7:0] idle_burst;  // idle_burst_bus_control
      logic [7:0] tristate;    // area_tristate_access_control
   } ebwc_cfg_type;

   typedef struct packed {
      logic [AXI_AW-1:0] awaddr;
      logic              awvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              wvalid;
      logic              bready;
      logic [AXI_AW-1:0] araddr;
      logic              arvalid;
      logic              rready;
   } ebwc_axi_req_type;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic [1:0]        bresp;
      logic              bvalid;
      logic              arready;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic              rvalid;
   } ebwc_axi_rsp_type;

   typedef struct packed {
      logic        valid;
      logic        external;
      logic        write;
      logic [1:0]  area;
      logic [23:0] addr;
      logic [15:0] wdata;
      logic [3:0]  words;
   } ebwc_acc_req_type;

   typedef struct packed {
      logic        valid;
      logic [15:0] rdata;
   } ebwc_acc_rsp_type;

   typedef struct packed {
      logic [23:0] addr;
      logic [3:0]  area_sel_n;
      logic        rd_n;
      logic        wr_n;
      logic [15:0] dout;
      logic        doe;
   } ebwc_ext_type;

endpackage : ebwc_pkg

// File: rtl/ebwc_regs.sv
// AXI4-Lite register slave holding the wait, idle/burst and three-state control registers
`timescale 1ns/100ps

module ebwc_regs (
   input  wire logic                      aclk,     // System clock
   input  wire logic                      aresetn,  // Synchronous reset, active low
   input  wire ebwc_pkg::ebwc_axi_req_type axi_req, // AXI4-Lite master side
   output      ebwc_pkg::ebwc_axi_rsp_type axi_rsp, // AXI4-Lite slave answers
   input  wire logic [7:0]                status,   // Controller state for readback
   output      ebwc_pkg::ebwc_cfg_type     cfg      // Register contents
);
   import ebwc_pkg::*;

   typedef struct packed {
      ebwc_cfg_type      cfg;
      logic              aw_held;
      logic [AXI_AW-1:0] awaddr;
      logic              w_held;
      logic [7:0]        wdata;
      logic              wlane0;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } ebwc_regs_st_type;

   ebwc_regs_st_type s_ff;
   ebwc_regs_st_type nxt_s;

   // Word-aligned decode; the upper half of the window is unmapped
   function automatic logic reg_mapped(input logic [AXI_AW-1:0] a);
      reg_mapped = (a[4] == 1'b0);
   endfunction : reg_mapped

   // ----------------------------------------------------------------
   // Channel handling
   // ----------------------------------------------------------------
   // Address and data are held separately so either may come first
   always_comb begin
      nxt_s = s_ff;
      if (s_ff.bvalid && axi_req.bready) begin
         nxt_s.bvalid = 1'b0;
      end
      if (s_ff.rvalid && axi_req.rready) begin
         nxt_s.rvalid = 1'b0;
      end
      if (axi_req.awvalid && !s_ff.aw_held && !s_ff.bvalid) begin
         nxt_s.aw_held = 1'b1;
         nxt_s.awaddr  = axi_req.awaddr;
      end
      if (axi_req.wvalid && !s_ff.w_held && !s_ff.bvalid) begin
         nxt_s.w_held = 1'b1;
         nxt_s.wdata  = axi_req.wdata[7:0];
         nxt_s.wlane0 = axi_req.wstrb[0];
      end
      // Both halves present: commit and answer
      if (s_ff.aw_held && s_ff.w_held) begin
         nxt_s.aw_held = 1'b0;
         nxt_s.w_held  = 1'b0;
         nxt_s.bvalid  = 1'b1;
         nxt_s.bresp   = reg_mapped(s_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
         if (s_ff.wlane0) begin
            if ({s_ff.awaddr[4:2], 2'b00} == OFS_WAIT_CTL) begin
               nxt_s.cfg.wait_ctl = s_ff.wdata;
            end
            if ({s_ff.awaddr[4:2], 2'b00} == OFS_IDLE_BURST) begin
               nxt_s.cfg.idle_burst = s_ff.wdata;
            end
            if ({s_ff.awaddr[4:2], 2'b00} == OFS_TRISTATE) begin
               nxt_s.cfg.tristate = s_ff.wdata;
            end
         end
      end
      // Reads answer one cycle after the address is taken
      if (axi_req.arvalid && !s_ff.rvalid) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp  = reg_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case ({axi_req.araddr[4:2], 2'b00})
            OFS_WAIT_CTL:   nxt_s.rdata = {24'h000000, s_ff.cfg.wait_ctl};
            OFS_IDLE_BURST: nxt_s.rdata = {24'h000000, s_ff.cfg.idle_burst};
            OFS_TRISTATE:   nxt_s.rdata = {24'h000000, s_ff.cfg.tristate};
            OFS_STATUS:     nxt_s.rdata = {24'h000000, status};
            default:        nxt_s.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff                 <= '0;
         s_ff.cfg.wait_ctl    <= WAIT_CTL_RST;
         s_ff.cfg.idle_burst  <= IDLE_BURST_RST;
         s_ff.cfg.tristate    <= TRISTATE_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Outputs
   always_comb begin
      axi_rsp         = '0;
      axi_rsp.awready = !s_ff.aw_held && !s_ff.bvalid;
      axi_rsp.wready  = !s_ff.w_held && !s_ff.bvalid;
      axi_rsp.bvalid  = s_ff.bvalid;
      axi_rsp.bresp   = s_ff.bresp;
      axi_rsp.arready = !s_ff.rvalid;
      axi_rsp.rvalid  = s_ff.rvalid;
      axi_rsp.rdata   = s_ff.rdata;
      axi_rsp.rresp   = s_ff.rresp;
   end
   assign cfg = s_ff.cfg;

endmodule : ebwc_regs

// File: testbench/ebwc_ext_mem.sv
// Behavioural external memory facing the controller's pins
`timescale 1ns/100ps

module ebwc_ext_mem (
   input  wire logic                   aclk,    // System clock
   input  wire ebwc_pkg::ebwc_ext_type ext_bus, // Pins from the controller
   output      logic [15:0]            rd_data  // Data towards the controller
);
   import ebwc_pkg::*;
   logic [15:0] last_ff = 16'h0000; // Last value put on the bus

   // --------------------------------------
   // Read data
   // --------------------------------------
   // Released bus shows the inverse of its last value, so stale data never matches
   always_comb begin
      rd_data = ~last_ff;
      if (!ext_bus.rd_n && !(&ext_bus.area_sel_n)) begin
         rd_data = ext_bus.addr[15:0] ^ 16'ha5a5;
      end
   end

   always_ff @(posedge aclk) begin
      last_ff <= rd_data;
   end
endmodule : ebwc_ext_mem

// File: testbench/test_ebwc_ctrl.sv
// Self-checking bench for the external bus wait, idle and burst controller
`timescale 1ns/100ps

module test_ebwc_ctrl;
   import ebwc_pkg::*;
   logic             aclk;
   logic             aresetn;
   ebwc_axi_req_type axi_req;
   ebwc_axi_rsp_type axi_rsp;
   ebwc_acc_req_type acc_req;
   logic             acc_ready;
   ebwc_acc_rsp_type acc_rsp;
   ebwc_ext_type     ext_bus;
   logic [15:0]      ext_data_i;
   int               num_errors;
   int               comparisons;
   int               cyc;
   logic [47:0]      expq[$];
   logic [47:0]      head;
   logic [31:0]      lfsr;
   logic [7:0]       ibc, wctl, ast;
   logic             last_rd;
   logic [1:0]       last_area;
   logic [7:0]       pats [4] = '{8'he4, 8'h39, 8'h4e, 8'h93};

   ebwc_ctrl uut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .acc_req(acc_req),
                  .acc_ready(acc_ready), .acc_rsp(acc_rsp), .ext_bus(ext_bus), .ext_data_i(ext_data_i));
   ebwc_ext_mem mem (.aclk(aclk), .ext_bus(ext_bus), .rd_data(ext_data_i));

   function automatic logic [31:0] nxt_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt_rand

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic give_verdict;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   // --------------------------------------
   // Register bus master
   // --------------------------------------
   task automatic axi_rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
      do @(negedge aclk); while (axi_rsp.arready !== 1'b1);
      @(posedge aclk);
      axi_req.arvalid <= 1'b0;
      do @(negedge aclk); while (axi_rsp.rvalid !== 1'b1);
      check("rdata", axi_rsp.rdata, d);
      check("rresp", axi_rsp.rresp, r);
      @(posedge aclk);
      axi_req.rready <= 1'b0;
      // One idle edge so a following read never re-raises rready in the same step
      @(posedge aclk);
   endtask : axi_rd

   // Writes a register, then reads it back
   task automatic set_reg(input logic [4:0] a, input logic [7:0] d);
      logic aw, w;
      axi_req.awaddr <= a;
      axi_req.wdata <= {24'h000000, d};
      axi_req.wstrb <= 4'hf;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw = axi_rsp.awready & axi_req.awvalid;
         w = axi_rsp.wready & axi_req.wvalid;
         @(posedge aclk);
         if (aw) axi_req.awvalid <= 1'b0;
         if (w) axi_req.wvalid <= 1'b0;
      end while (axi_req.awvalid && !aw || axi_req.wvalid && !w);
      do @(negedge aclk); while (axi_rsp.bvalid !== 1'b1);
      check("bresp", axi_rsp.bresp, RESP_OKAY);
      @(posedge aclk);
      axi_req.bready <= 1'b0;
      axi_rd(a, {24'h000000, d}, RESP_OKAY);
   endtask : set_reg

   // --------------------------------------
   // CPU access driver, notes expected cycle and data per word
   // --------------------------------------
   task automatic acc(input logic ext, input logic wr, input logic [1:0] ar, input logic [3:0] wd);
      logic [23:0] ad;
      int          lat, n, lim;
      lfsr = nxt_rand(lfsr);
      ad = {lfsr[23:1], 1'b0};
      lim = ibc[IB_BURST_CNT] ? 8 : 4;
      n = (ext && !wr && ar == 2'h0 && ibc[IB_BURST_EN]) ? ((wd == 0) ? 1 : (wd > lim) ? lim : wd) : 1;
      lat = 1;
      if (ext) begin
         lat = (last_rd && ((!wr && ar != last_area && ibc[IB_CROSS_READ]) || (wr && ibc[IB_READ_WRITE])));
         lat += ast[ar] ? 4 + wctl[{ar, 1'b0}+:2] : 3;
      end
      last_rd = ext && !wr;
      last_area = ar;
      acc_req <= '{1'b1, ext, wr, ar, ad, lfsr[31:16], wd};
      do @(negedge aclk); while (acc_ready !== 1'b1);
      for (int k = 0; k < n; k++) begin
         expq.push_back({32'(cyc + lat + k * (ibc[IB_BURST_LEN] ? 2 : 1)),
                         (ext && !wr) ? 16'(ad + 2 * k) ^ 16'ha5a5 : 16'h0000});
      end
      @(posedge aclk);
      acc_req.valid <= 1'b0;
      while (expq.size() > 0) @(posedge aclk);
   endtask : acc

   // Completion watcher, compares each pulse with the oldest note
   always @(negedge aclk) begin
      if (acc_rsp.valid === 1'b1) begin
         head = (expq.size() > 0) ? expq.pop_front() : 48'hffffffff0000;
         check("rsp_cycle", cyc, head[47:16]);
         check("rsp_data", acc_rsp.rdata, head[15:0]);
      end
   end

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // Cycle count and hang limit
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         give_verdict;
      end
   end

   initial begin
      axi_req = '0;
      acc_req = '0;
      aresetn = 1'b0;
      {cyc, num_errors, comparisons} = '0;
      lfsr = 32'hf4c9;
      {ibc, wctl, ast} = {IDLE_BURST_RST, WAIT_CTL_RST, TRISTATE_RST};
      {last_rd, last_area} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(OFS_WAIT_CTL, 32'h000000ff, RESP_OKAY);
      axi_rd(OFS_IDLE_BURST, 32'h000000d0, RESP_OKAY);
      axi_rd(OFS_TRISTATE, 32'h000000ff, RESP_OKAY);
      axi_rd(5'h10, 32'h00000000, RESP_SLVERR);
      for (int a = 0; a < 4; a++) begin
         acc(1'b1, 1'b0, a[1:0], 4'h1);
         acc(1'b0, 1'b0, a[1:0], 4'h1);
         acc(1'b1, 1'b1, a[1:0], 4'h1);
      end
      // Every code in every field position, random direction
      foreach (pats[i]) begin
         wctl = pats[i];
         set_reg(OFS_WAIT_CTL, wctl);
         for (int a = 0; a < 4; a++) acc(1'b1, lfsr[0], a[1:0], 4'h1);
      end
      ast = 8'hf5;
      set_reg(OFS_TRISTATE, ast);
      for (int a = 0; a < 4; a++) acc(1'b1, lfsr[0], a[1:0], 4'h1);
      for (int i = 0; i < 4; i++) begin
         ibc = 8'(i << 6);
         set_reg(OFS_IDLE_BURST, ibc);
         acc(1'b1, 1'b0, 2'h0, 4'h1);
         acc(1'b1, 1'b0, 2'h1, 4'h1);
         acc(1'b1, 1'b0, 2'h1, 4'h1);
         acc(1'b1, 1'b1, 2'h3, 4'h1);
      end
      // Burst length and word limit combinations, plus a disabled burst
      for (int i = 0; i < 5; i++) begin
         ibc = (i < 4) ? 8'(8'h20 | (i << 3)) : 8'h18;
         set_reg(OFS_IDLE_BURST, ibc);
         acc(1'b1, 1'b0, 2'h0, 4'hf);
         acc(1'b1, 1'b0, 2'h0, 4'h0);
         acc(1'b1, 1'b0, 2'h0, 4'h3);
         acc(1'b1, 1'b0, 2'h1, 4'hf);
      end
      give_verdict;
   end
endmodule : test_ebwc_ctrl
